/* File: src/otp_word_program_sequencer.sv */
// What this block does
// - hold chip select low one 50 us pulse
// - start at first address, supplies raised
// - one unverified pulse per address first
// - on mismatch, pulse and verify, up to 10
// - still failing after 10: report part failed
// - verified word advances to next address
// - lower supplies, reread and compare each word up to the first mismatch
// - id voltage on id pin enters identification
`timescale 1ns/1ps
`include "otp_regs.svh"

module otp_word_program_sequencer #(
    parameter logic [15:0] PULSE_CYC = 16'(`OTP_T_PW_NS / `OTP_CLK_NS), // pulse cycles
    parameter logic [17:0] LAST_ADDR = `OTP_ADDR_LAST                   // last word to program
) (
    input  wire logic               ref_clk_i,    // 200 MHz clock
    input  wire logic               rst_n_i,      // async reset, active low
    input  wire logic               start_prog_i, // start programming run
    input  wire logic               start_id_i,   // start identification read
    input  wire logic [15:0]        src_data_i,   // source word for src_addr_o
    input  wire logic [15:0]        data_i,       // data pins as seen at the memory
    output otp_pkg::otp_pins_t      pins_o,       // pins toward the memory
    output logic      [17:0]        src_addr_o,   // address whose source word is wanted
    output otp_pkg::otp_stat_t      stat_o,       // result flags
    output logic      [15:0]        id_mfr_o,     // manufacturer code read back
    output logic      [15:0]        id_dev_o      // device-type code read back
);

    // ------------------------------------------------------------------
    // timing helpers
    // ------------------------------------------------------------------
    // least times round up to whole cycles
    function automatic logic [15:0] cyc_up(input int ns);
        cyc_up = 16'((ns + `OTP_CLK_NS - 1) / `OTP_CLK_NS);
    endfunction : cyc_up

    localparam logic [15:0] SETUP_CYC = cyc_up(`OTP_T_SETUP_NS);                   // 2 us
    localparam logic [15:0] READ_CYC  = 16'(cyc_up(`OTP_T_OE_NS) + `OTP_SYNC_CYC); // tOE + filter
    localparam logic [15:0] FLOAT_CYC = cyc_up(`OTP_T_DFP_NS);                     // bus turnaround

    // ------------------------------------------------------------------
    // data pin input filter
    // ------------------------------------------------------------------
    logic [15:0] sync1_reg, sync2_reg, sync3_reg; // three-stage chain
    logic [15:0] filt_reg,  filt_next;            // accepted pin value

    // a new value counts only once stages two and three agree
    always_comb begin
        filt_next = (sync2_reg == sync3_reg) ? sync3_reg : filt_reg;
    end

    // registers of the filter only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            sync3_reg <= 16'h0000;
            filt_reg  <= 16'h0000;
        end else begin
            sync1_reg <= data_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    otp_pkg::otp_state_t state_reg, state_next; // sequence step
    otp_pkg::otp_pins_t  pins_reg,  pins_next;  // all pins come from flops
    otp_pkg::otp_stat_t  stat_reg,  stat_next;  // result flags
    logic [15:0]         tmr_reg,   tmr_next;   // step timer, counts down
    logic [3:0]          retry_reg, retry_next; // further pulses on this word
    logic [15:0]         mfr_reg,   mfr_next;   // captured maker code
    logic [15:0]         dev_reg,   dev_next;   // captured type code
    logic                tmr_zero;              // current step has elapsed

    assign tmr_zero = (tmr_reg == 16'h0000);

    // next-state logic of the whole sequence
    always_comb begin
        state_next     = state_reg;
        pins_next      = pins_reg;
        stat_next      = stat_reg;
        stat_next.done = 1'b0;
        tmr_next       = tmr_zero ? 16'h0000 : tmr_reg - 16'h0001;
        retry_next     = retry_reg;
        mfr_next       = mfr_reg;
        dev_next       = dev_reg;
        case (state_reg)
            // waiting for a request; programming wins a tie
            otp_pkg::ST_IDLE: begin
                if (start_prog_i) begin
                    pins_next.addr        = `OTP_ADDR_FIRST;
                    pins_next.supply_prog = 1'b1;
                    retry_next            = 4'h0;
                    stat_next.busy        = 1'b1;
                    stat_next.pass        = 1'b0;
                    stat_next.fail        = 1'b0;
                    tmr_next              = SETUP_CYC;
                    state_next            = otp_pkg::ST_RAISE;
                end else if (start_id_i) begin
                    pins_next.id_volt = 1'b1;
                    // bit zero low selects maker code
                    pins_next.addr    = `OTP_ADDR_FIRST;
                    pins_next.ce_n    = 1'b0;
                    pins_next.oe_n    = 1'b0;
                    stat_next.busy    = 1'b1;
                    tmr_next          = 16'(SETUP_CYC + READ_CYC);
                    state_next        = otp_pkg::ST_IDRD;
                end
            end
            // supplies settling, or memory outputs floating, before we drive data
            otp_pkg::ST_RAISE: begin
                if (tmr_zero) begin
                    pins_next.data    = src_data_i;
                    pins_next.data_oe = 1'b1;
                    tmr_next          = SETUP_CYC;
                    state_next        = otp_pkg::ST_SETUP;
                end
            end
            // address and data setup ahead of the pulse
            otp_pkg::ST_SETUP: begin
                if (tmr_zero) begin
                    // chip select low for the pulse
                    pins_next.ce_n = 1'b0;
                    tmr_next       = 16'(PULSE_CYC - 16'h0001);
                    state_next     = otp_pkg::ST_PULSE;
                end
            end
            // program pulse in progress
            otp_pkg::ST_PULSE: begin
                if (tmr_zero) begin
                    pins_next.ce_n = 1'b1;
                    tmr_next       = SETUP_CYC;
                    state_next     = otp_pkg::ST_HOLD;
                end
            end
            // data hold, then turn the bus round for verify
            otp_pkg::ST_HOLD: begin
                if (tmr_zero) begin
                    pins_next.data_oe = 1'b0;
                    pins_next.oe_n    = 1'b0;
                    tmr_next          = READ_CYC;
                    state_next        = otp_pkg::ST_VREAD;
                end
            end
            // verify read of the word just pulsed
            otp_pkg::ST_VREAD: begin
                if (tmr_zero) begin
                    pins_next.oe_n = 1'b1;
                    tmr_next       = SETUP_CYC;
                    if (filt_reg == src_data_i) begin
                        if (pins_reg.addr == LAST_ADDR) begin
                            pins_next.supply_prog = 1'b0;
                            state_next            = otp_pkg::ST_LOWER;
                        end else begin
                            pins_next.addr    = pins_reg.addr + 18'h00001;
                            retry_next        = 4'h0;
                            // memory may still drive until it floats
                            state_next        = otp_pkg::ST_RAISE;
                            tmr_next          = FLOAT_CYC;
                        end
                    end else if (retry_reg < `OTP_RETRY_MAX) begin
                        retry_next        = retry_reg + 4'h1;
                        // wait for the float before driving, avoids contention
                        tmr_next          = FLOAT_CYC;
                        state_next        = otp_pkg::ST_RAISE;
                    end else begin
                        pins_next.supply_prog = 1'b0;
                        stat_next.fail        = 1'b1;
                        stat_next.busy        = 1'b0;
                        stat_next.done        = 1'b1;
                        state_next            = otp_pkg::ST_IDLE;
                    end
                end
            end
            // supplies falling back to 5.0 V
            otp_pkg::ST_LOWER: begin
                if (tmr_zero) begin
                    pins_next.addr = `OTP_ADDR_FIRST;
                    pins_next.ce_n = 1'b0;
                    pins_next.oe_n = 1'b0;
                    tmr_next       = READ_CYC;
                    state_next     = otp_pkg::ST_FREAD;
                end
            end
            // final compare of the array, stopping at the first mismatch
            otp_pkg::ST_FREAD: begin
                if (tmr_zero) begin
                    if (filt_reg != src_data_i || pins_reg.addr == LAST_ADDR) begin
                        pins_next.ce_n = 1'b1;
                        pins_next.oe_n = 1'b1;
                        stat_next.pass = (filt_reg == src_data_i);
                        stat_next.fail = (filt_reg != src_data_i);
                        stat_next.busy = 1'b0;
                        stat_next.done = 1'b1;
                        state_next     = otp_pkg::ST_IDLE;
                    end else begin
                        pins_next.addr = pins_reg.addr + 18'h00001;
                        tmr_next       = READ_CYC;
                    end
                end
            end
            // identification reads, maker then type
            otp_pkg::ST_IDRD: begin
                if (tmr_zero) begin
                    if (!pins_reg.addr[0]) begin
                        mfr_next          = filt_reg;
                        // bit zero high selects type code
                        pins_next.addr[0] = 1'b1;
                        tmr_next          = READ_CYC;
                    end else begin
                        dev_next              = filt_reg;
                        stat_next.id_upper_ok = (mfr_reg[15:8] == `OTP_UPPER_ZERO)
                                              && (filt_reg[15:8] == `OTP_UPPER_ZERO);
                        pins_next.id_volt     = 1'b0;
                        pins_next.ce_n        = 1'b1;
                        pins_next.oe_n        = 1'b1;
                        stat_next.busy        = 1'b0;
                        stat_next.done        = 1'b1;
                        state_next            = otp_pkg::ST_IDLE;
                    end
                end
            end
            // unreachable codes fall back to a safe idle
            default: begin
                pins_next.ce_n        = 1'b1;
                pins_next.oe_n        = 1'b1;
                pins_next.data_oe     = 1'b0;
                pins_next.supply_prog = 1'b0;
                pins_next.id_volt     = 1'b0;
                state_next            = otp_pkg::ST_IDLE;
            end
        endcase
        // source word follows the address while we drive the bus
        if (pins_next.data_oe) begin
            pins_next.data = src_data_i;
        end
    end

    // registers of the sequencer only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= otp_pkg::ST_IDLE;
            pins_reg  <= '{addr: 18'h00000, data: 16'h0000, data_oe: 1'b0, ce_n: 1'b1,
                           oe_n: 1'b1, supply_prog: 1'b0, id_volt: 1'b0};
            stat_reg  <= '0;
            tmr_reg   <= 16'h0000;
            retry_reg <= 4'h0;
            mfr_reg   <= 16'h0000;
            dev_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            pins_reg  <= pins_next;
            stat_reg  <= stat_next;
            tmr_reg   <= tmr_next;
            retry_reg <= retry_next;
            mfr_reg   <= mfr_next;
            dev_reg   <= dev_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign pins_o     = pins_reg;
    assign src_addr_o = pins_reg.addr;
    assign stat_o     = stat_reg;
    assign id_mfr_o   = mfr_reg;
    assign id_dev_o   = dev_reg;

endmodule : otp_word_program_sequencer

/* File: inc/otp_regs.svh */
`ifndef OTP_REGS_SVH
`define OTP_REGS_SVH
// ----------------------------------------------------------------------
// widths and timing constants for the one-time-programmable memory
// ----------------------------------------------------------------------
`define OTP_ADDR_W        18          // word address pins
`define OTP_DATA_W        16          // word data pins
`define OTP_CLK_NS        5           // reference clock period, ns
`define OTP_T_PW_NS       50000       // program_pulse_width nominal, ns
`define OTP_T_SETUP_NS    2000        // address, data, supply, oe setup and data hold, ns
`define OTP_T_OE_NS       150         // data valid from output enable, ns
`define OTP_T_DFP_NS      130         // memory output float after oe high, ns
`define OTP_SYNC_CYC      16'h0004    // extra cycles for the 3-stage input filter
`define OTP_RETRY_MAX     4'hA        // further pulses allowed after the first
`define OTP_ADDR_FIRST    18'h00000   // first array location
`define OTP_ADDR_LAST     18'h3FFFF   // last array location
`define OTP_UPPER_ZERO    8'h00       // upper_output_byte in identification mode
`endif

/* File: inc/otp_pkg.sv */
// ----------------------------------------------------------------------
// types shared by the programmer and its bench
// ----------------------------------------------------------------------
package otp_pkg;
    // pins driven toward the memory
    typedef struct packed {
        logic [17:0] addr;         // address pins
        logic [15:0] data;         // data pins, driven while data_oe
        logic        data_oe;      // high while we drive the data pins
        logic        ce_n;         // chip select, program pulse when low
        logic        oe_n;         // output enable
        logic        supply_prog;  // 1: 6.5 V core / 13.0 V prog, 0: both 5.0 V
        logic        id_volt;      // id_select_voltage on id_select_address_pin
    } otp_pins_t;

    // result flags toward the user
    typedef struct packed {
        logic busy;                // sequence running
        logic done;                // one-cycle pulse at end of a sequence
        logic pass;                // last program run passed
        logic fail;                // last program run failed
        logic id_upper_ok;         // both id words had a zero upper byte
    } otp_stat_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_RAISE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_PULSE = 4'b0011,
        ST_HOLD  = 4'b0100,
        ST_VREAD = 4'b0101,
        ST_LOWER = 4'b0110,
        ST_FREAD = 4'b0111,
        ST_IDRD  = 4'b1000
    } otp_state_t;
endpackage : otp_pkg

/* File: bench/otp_seq_asserts.sv */
`timescale 1ns/1ps
module otp_seq_asserts #(
    parameter logic [15:0] PULSE_CYC = 16'h0014,
    parameter logic [17:0] LAST_ADDR = 18'h00003
) (
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               start_prog_i,
    input  wire logic               start_id_i,
    input  wire logic [15:0]        src_data_i,
    input  wire logic [15:0]        data_i,
    input  wire otp_pkg::otp_pins_t pins_o,
    input  wire logic [17:0]        src_addr_o,
    input  wire otp_pkg::otp_stat_t stat_o,
    input  wire logic [15:0]        id_mfr_o,
    input  wire logic [15:0]        id_dev_o
);
    // ------------------------------------------------------------
    // helper counters: low time of chip select, pulses per word
    // ------------------------------------------------------------
    logic [15:0] lo_cnt_reg, lo_cnt_next; // cycles chip select low
    logic [4:0]  pc_reg, pc_next;         // pulses on current address
    logic        ce_prev_reg;             // chip select one cycle ago
    logic [17:0] addr_prev_reg;           // address one cycle ago
    // next values; count clears when the address moves
    always_comb begin
        lo_cnt_next = pins_o.ce_n ? 16'h0000 : lo_cnt_reg + 16'h0001;
        pc_next = (!stat_o.busy || pins_o.addr != addr_prev_reg) ? 5'h00 :
                  pc_reg + 5'(ce_prev_reg && !pins_o.ce_n && pins_o.supply_prog);
    end
    // registers only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_cnt_reg    <= 16'h0000;
            pc_reg        <= 5'h00;
            ce_prev_reg   <= 1'b1;
            addr_prev_reg <= 18'h00000;
        end else begin
            lo_cnt_reg    <= lo_cnt_next;
            pc_reg        <= pc_next;
            ce_prev_reg   <= pins_o.ce_n;
            addr_prev_reg <= pins_o.addr;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // read enable stays off until the first pulse of a new word
    sequence s_first_pulse;
        pins_o.oe_n throughout (##[1:1000] $fell(pins_o.ce_n));
    endsequence
    sequence s_quiet_wait;
        (pins_o.ce_n && !pins_o.data_oe) [*8];
    endsequence
    a_pulse_width: assert property ($rose(pins_o.ce_n) && pins_o.supply_prog |->
        lo_cnt_reg == PULSE_CYC) else $error("program pulse width wrong");
    a_pulse_data: assert property (!pins_o.ce_n && pins_o.supply_prog |->
        pins_o.data_oe && pins_o.data == src_data_i) else $error("pulse without data");
    a_raise_start: assert property (start_prog_i && !stat_o.busy |=>
        pins_o.supply_prog && stat_o.busy && pins_o.addr == 18'h00000)
        else $error("run did not start raised at first word");
    a_first_unverified: assert property ($changed(pins_o.addr) && pins_o.supply_prog
        |-> s_first_pulse) else $error("verify before first pulse");
    a_retry_cap: assert property (pc_reg <= 5'h0B)
        else $error("too many pulses on one word");
    a_fail_stop: assert property ($rose(stat_o.fail) |->
        stat_o.done && !stat_o.busy && !pins_o.supply_prog) else $error("fail not final");
    a_addr_range: assert property (pins_o.supply_prog |-> pins_o.addr <= LAST_ADDR)
        else $error("address beyond last word");
    a_final_lower: assert property ($fell(pins_o.supply_prog) && !stat_o.fail
        |-> s_quiet_wait) else $error("final read too early");
    a_pass_low: assert property ($rose(stat_o.pass) |->
        stat_o.done && !pins_o.supply_prog) else $error("pass at raised supply");
    a_id_upper: assert property ($fell(pins_o.id_volt) |-> stat_o.done &&
        stat_o.id_upper_ok == (id_mfr_o[15:8] == 8'h00 && id_dev_o[15:8] == 8'h00))
        else $error("id upper byte flag wrong");
    a_id_entry: assert property (start_id_i && !start_prog_i && !stat_o.busy |=>
        pins_o.id_volt && !pins_o.ce_n && !pins_o.oe_n && pins_o.addr == 18'h00000)
        else $error("id mode not entered");
endmodule : otp_seq_asserts

/* File: bench/otp_mem_model.sv */
`timescale 1ns/1ps
// four-word memory; a word takes only after need_i pulses
module otp_mem_model #(
    parameter logic [7:0] MFR_CODE = 8'h5C, // arbitrary maker code
    parameter logic [7:0] DEV_CODE = 8'hA3  // arbitrary type code
) (
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    input  wire otp_pkg::otp_pins_t pins_i,
    input  wire logic [3:0][3:0]    need_i,    // pulses each word needs
    input  wire logic               corrupt_i, // flip bit 0 at normal supply
    output logic      [15:0]        drive_o,
    output logic      [3:0][3:0]    pulses_o,  // pulses seen per word
    output logic      [15:0]        width_o    // last pulse length
);
    logic [15:0] mem_reg [4];  // array contents
    logic [15:0] lo_reg;       // chip select low count
    logic [15:0] last_reg;     // last value driven
    logic [15:0] rd_val;       // value on a read
    logic [1:0]  a;            // word index
    assign a = pins_i.addr[1:0];
    assign rd_val = pins_i.id_volt ? {8'h00, pins_i.addr[0] ? DEV_CODE : MFR_CODE} :
                    mem_reg[a] ^ {15'h0000, corrupt_i && !pins_i.supply_prog};
    // released pins show the inverse of the last value, not a stale copy
    assign drive_o = pins_i.oe_n ? ~last_reg : rd_val;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulses_o <= '0;
            width_o  <= 16'h0000;
            lo_reg   <= 16'h0000;
            last_reg <= 16'h0000;
            for (int k = 0; k < 4; k++) mem_reg[k] <= 16'hFFFF;
        end else begin
            lo_reg <= pins_i.ce_n ? 16'h0000 : lo_reg + 16'h0001;
            if (!pins_i.oe_n) last_reg <= rd_val;
            if (pins_i.ce_n && lo_reg != 16'h0000 && pins_i.supply_prog && pins_i.data_oe) begin
                width_o     <= lo_reg;
                pulses_o[a] <= pulses_o[a] + 4'h1;
                mem_reg[a]  <= (pulses_o[a] + 4'h1 >= need_i[a]) ? pins_i.data : ~pins_i.data;
            end
        end
    end
endmodule : otp_mem_model

/* File: bench/test_otp_word_program_sequencer.sv */
`timescale 1ns/1ps
module test_otp_word_program_sequencer;
    localparam logic [15:0] PULSE = 16'h0014; // short pulse for sim
    localparam logic [17:0] LAST  = 18'h00003;
    localparam logic [7:0]  MFR   = 8'h5C;    // arbitrary
    localparam logic [7:0]  DEV   = 8'hA3;    // arbitrary
    logic clk, rst_n, start_prog, start_id, corrupt;
    logic [3:0][3:0] need, pulses;
    logic [15:0] src_mem [4];
    logic [15:0] src_data, mdrive, data_w, id_mfr, id_dev, width;
    logic [17:0] src_addr;
    logic [32:0] note;
    otp_pkg::otp_pins_t pins;
    otp_pkg::otp_stat_t stat;
    int err_count, checks_done, seed;
    logic [32:0] note_q [$];       // expected results in order
    assign src_data = src_mem[src_addr[1:0]];
    assign data_w = pins.data_oe ? pins.data : mdrive; // resolved data pins
    otp_word_program_sequencer #(.PULSE_CYC(PULSE), .LAST_ADDR(LAST))
        otp_word_program_sequencer_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
        .start_prog_i(start_prog), .start_id_i(start_id), .src_data_i(src_data),
        .data_i(data_w), .pins_o(pins), .src_addr_o(src_addr), .stat_o(stat),
        .id_mfr_o(id_mfr), .id_dev_o(id_dev));
    otp_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) otp_mem_model_inst (.ref_clk_i(clk),
        .rst_n_i(rst_n), .pins_i(pins), .need_i(need), .corrupt_i(corrupt),
        .drive_o(mdrive), .pulses_o(pulses), .width_o(width));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task final_report;
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // one run after a fresh reset; note is queued before the start
    task run(input logic is_id, input logic [15:0] nd, input logic cor);
        logic       bad;
        logic [3:0] ep;
        int         k;
        bad = cor;
        for (k = 0; k < 4; k++) if (nd[k*4 +: 4] > 4'hB) bad = 1'b1;
        @(posedge clk);
        #1 rst_n = 1'b0;
        need = nd;
        corrupt = cor;
        for (k = 0; k < 4; k++) src_mem[k] = 16'($random(seed));
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        note_q.push_back(is_id ? {1'b1, 8'h00, MFR, 8'h00, DEV} : {1'b0, 30'h0, !bad, bad});
        start_id = is_id;
        start_prog = !is_id;
        @(posedge clk);
        #1 start_id = 1'b0;
        start_prog = 1'b0;
        k = 0;
        // bound sits above the longest run; a hang counts as a mismatch
        while (stat.done !== 1'b1 && k < 20000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000) err_count++;
        else if (is_id) check("id_upper_ok", 32'(stat.id_upper_ok), 32'h1);
        else begin
            bad = 1'b0;
            for (k = 0; k < 4; k++) begin
                ep = bad ? 4'h0 : (nd[k*4 +: 4] > 4'hB ? 4'hB : nd[k*4 +: 4]);
                check("pulses", 32'(pulses[k]), 32'(ep));
                if (nd[k*4 +: 4] > 4'hB) bad = 1'b1;
            end
            check("pulse_width", 32'(width), 32'(PULSE));
        end
    endtask : run
    // watcher: each done pulse takes the oldest note
    always @(negedge clk) begin
        if (stat.done === 1'b1) begin
            if (note_q.size() == 0) check("note", 32'h0, 32'h1);
            else begin
                note = note_q.pop_front();
                check("result", note[32] ? {id_mfr, id_dev} :
                      {30'h0, stat.pass, stat.fail}, note[31:0]);
            end
        end
    end
    initial begin
        rst_n = 1'b0;
        start_prog = 1'b0;
        start_id = 1'b0;
        corrupt = 1'b0;
        need = '0;
        err_count = 0;
        checks_done = 0;
        seed = 81113;
        for (int k = 0; k < 4; k++) src_mem[k] = 16'h0000;
        run(1'b1, 16'h1111, 1'b0);  // identification read
        run(1'b0, 16'h1B31, 1'b0);  // retries up to the limit, passes
        run(1'b0, 16'h11C1, 1'b0);  // word 1 never takes
        run(1'b0, 16'h1111, 1'b1);  // final compare mismatch
        final_report();
    end
endmodule : test_otp_word_program_sequencer
bind otp_word_program_sequencer otp_seq_asserts #(.PULSE_CYC(PULSE_CYC),
    .LAST_ADDR(LAST_ADDR)) otp_seq_asserts_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .start_prog_i(start_prog_i), .start_id_i(start_id_i), .src_data_i(src_data_i),
    .data_i(data_i), .pins_o(pins_o), .src_addr_o(src_addr_o), .stat_o(stat_o),
    .id_mfr_o(id_mfr_o), .id_dev_o(id_dev_o));
